// *** pkg/tacs_pkg.sv ***
// Package for the timer array clock and mode select block
`default_nettype none
package tacs_pkg;
    localparam int          TACS_CHANNELS      = 4;
    localparam logic [19:0] TACS_PRESCALE_ADDR = 20'hf01b6;
    localparam logic [19:0] TACS_MODE0_ADDR    = 20'hf0190;
    localparam logic [15:0] TACS_RESET_VALUE   = 16'h0000;
    // Prescaler select fields
    localparam int TACS_PS0_LSB = 0;
    localparam int TACS_PS1_LSB = 4;
    localparam int TACS_PS2_LSB = 8;
    localparam int TACS_PS3_LSB = 12;
    localparam logic [15:0] TACS_PS_WMASK = 16'h33ff;
    // Mode register fields
    localparam int TACS_OPCLK_LSB = 14;
    localparam int TACS_CSRC_BIT  = 12;
    localparam int TACS_B11_BIT   = 11;
    localparam int TACS_TRIG_LSB  = 8;
    localparam int TACS_EDGE_LSB  = 6;
    localparam int TACS_FUNC_LSB  = 0;
    localparam logic [15:0] TACS_MODE_WMASK = 16'hdfcf;
    // Edge polarity codes
    localparam logic [1:0] TACS_EDGE_FALL = 2'h0;
    localparam logic [1:0] TACS_EDGE_RISE = 2'h1;
    // Prescaler divide exponents for the reduced clocks
    localparam logic [3:0] TACS_PS2_EXP0 = 4'h1;
    localparam logic [3:0] TACS_PS2_EXP1 = 4'h2;
    localparam logic [3:0] TACS_PS2_EXP2 = 4'h4;
    localparam logic [3:0] TACS_PS2_EXP3 = 4'h6;
    localparam logic [3:0] TACS_PS3_EXP0 = 4'h8;
    localparam logic [3:0] TACS_PS3_EXP1 = 4'ha;
    localparam logic [3:0] TACS_PS3_EXP2 = 4'hc;
    localparam logic [3:0] TACS_PS3_EXP3 = 4'he;
endpackage
`default_nettype wire

// *** verilog/tacs_top.sv ***
// Prescaler, operation clock and count source selection for four timer channels
`default_nettype none
// Summary of operation
// RULE_01 - Clock 2 ratio codes 0..3 give core clock divided by 2, 4, 16, 64.
// RULE_02 - Clock 3 ratio codes 0..3 give core clock divided by 2^8..2^14 in steps of four.
// RULE_03 - Each prescaled clock is a one-cycle-high pulse per division interval.
// RULE_04 - Software stops all channels before changing the core clock source.
// RULE_05 - Software writes zero to prescaler bits 15, 14, 11 and 10.
// RULE_06 - Software rewrites a running channel's mode only in edge polarity bits.
// RULE_07 - Mode registers are written as whole 16-bit words and reset to zero.
// RULE_08 - Bit 11: lead flag on channel 2, half-width on 1 and 3, zero on 0.
// RULE_09 - A fixed bit 11 reads zero and ignores writes.
// RULE_10 - Mode layout: clock, zero, source, bit 11, trigger, edge, zeros, function.
// RULE_11 - Clock codes 00, 01, 10, 11 pick prescaled clocks 0, 2, 1, 3.
// RULE_12 - Only channels 1 and 3 may use prescaled clocks 2 or 3.
// RULE_13 - Operation clock paces the edge detector; count clock derived per source select.
// RULE_14 - Source 0 counts operation clock; source 1 counts valid input edges.
// RULE_15 - The count clock is delivered to counter, output and interrupt logic.
// RULE_16 - Half-width channels 1 and 3 may time intervals from clocks 2 or 3.
// RULE_17 - Prescaler fields: clock0 bits 3:0, clock1 7:4, clock2 9:8, clock3 13:12.
// RULE_18 - Software rewrites a ratio only while channels using it are stopped.
// RULE_19 - Clock 0 and 1 fields divide core clock by 2^k, k from 0 to 15.
// RULE_20 - Reserved and fixed-zero bits read as zero.
// RULE_21 - Everything runs on one clock; prescaled clocks and edges are enables.
module tacs_top
    import tacs_pkg::*;
#(
    parameter int CHANNELS = TACS_CHANNELS
)
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    // Register access port
    input  wire logic [19:0]           reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [15:0]           reg_wdata,
    output logic      [15:0]           reg_rdata,
    // Channel pins and route select
    input  wire logic [CHANNELS-1:0]   timer_input_pin,
    input  wire logic                  input_route_alt,
    input  wire logic                  input_route_sel,
    input  wire logic [CHANNELS-1:0]   channel_running,
    // Enables toward the channel counters
    output logic [3:0]                 prescaled_clock,
    output logic [CHANNELS-1:0]        op_clock_en,
    output logic [CHANNELS-1:0]        sample_en,
    output logic [CHANNELS-1:0]        count_clock_en,
    output logic [CHANNELS-1:0]        half_width,
    output logic [CHANNELS-1:0]        lead_channel
);
    // Bit 11 decode and the clock 2/3 restriction assume exactly four channels
    if (CHANNELS != 4)
    begin : g_channel_check
        $error("tacs_top supports exactly four channels");
    end

    // Reset release through two flops
    // Release is synchronous, so every flop leaves reset on the same edge
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire logic rst_n = rst_sync_q;

    // Pin inputs pass two flops before any logic
    // Only the second flop is read; the first may still be settling
    logic [CHANNELS-1:0] pin_meta_q;
    logic [CHANNELS-1:0] pin_sync_q;
    logic                alt_meta_q;
    logic                alt_sync_q;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
            alt_meta_q <= 1'b0;
            alt_sync_q <= 1'b0;
        end
        else
        begin
            pin_meta_q <= timer_input_pin;
            pin_sync_q <= pin_meta_q;
            alt_meta_q <= input_route_alt;
            alt_sync_q <= alt_meta_q;
        end
    end

    // Register file state
    // Read data is registered: a read answers one cycle after its strobe
    logic [15:0] ps_q;
    logic [15:0] ps_d;
    logic [15:0] mode_q [CHANNELS];
    logic [15:0] mode_d [CHANNELS];
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    // Bit 11 is writable only on channels 1, 2 and 3
    function automatic logic [15:0] mode_mask(input int ch);
        logic [15:0] m;
        m = TACS_MODE_WMASK;
        if (ch == 0)
            m[TACS_B11_BIT] = 1'b0; // see RULE_08 see RULE_09
        return m;
    endfunction

    // Register writes and read mux
    always_comb
    begin
        ps_d    = ps_q;
        rdata_d = rdata_q;
        for (int i = 0; i < CHANNELS; i++)
            mode_d[i] = mode_q[i];
        if (reg_wr && reg_addr == TACS_PRESCALE_ADDR)
            ps_d = reg_wdata & TACS_PS_WMASK; // see RULE_17 see RULE_20
        for (int i = 0; i < CHANNELS; i++)
        begin
            // Whole-word write; unused bits are forced to zero
            if (reg_wr && reg_addr == TACS_MODE0_ADDR + 20'(2 * i))
                mode_d[i] = reg_wdata & mode_mask(i); // see RULE_07 see RULE_10 see RULE_20
        end
        if (reg_rd)
        begin
            rdata_d = 16'h0000; // Unmapped addresses read zero
            if (reg_addr == TACS_PRESCALE_ADDR)
                rdata_d = ps_q;
            for (int i = 0; i < CHANNELS; i++)
            begin
                if (reg_addr == TACS_MODE0_ADDR + 20'(2 * i))
                    rdata_d = mode_q[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ps_q    <= TACS_RESET_VALUE;
            rdata_q <= TACS_RESET_VALUE;
            for (int i = 0; i < CHANNELS; i++)
                mode_q[i] <= TACS_RESET_VALUE; // see RULE_07
        end
        else
        begin
            ps_q    <= ps_d;
            rdata_q <= rdata_d;
            for (int i = 0; i < CHANNELS; i++)
                mode_q[i] <= mode_d[i];
        end
    end

    // Free-running prescaler counter shared by all four clocks
    // A ratio change acts at once; software keeps the affected channels stopped
    logic [14:0] div_q;
    logic [14:0] div_d;
    logic [3:0]  exp_sel [4];
    logic [3:0]  tick;
    always_comb
    begin
        div_d = div_q + 15'h0001;
        exp_sel[0] = ps_q[TACS_PS0_LSB +: 4]; // see RULE_19
        exp_sel[1] = ps_q[TACS_PS1_LSB +: 4]; // see RULE_19
        unique case (ps_q[TACS_PS2_LSB +: 2]) // see RULE_01
            2'h0: exp_sel[2] = TACS_PS2_EXP0;
            2'h1: exp_sel[2] = TACS_PS2_EXP1;
            2'h2: exp_sel[2] = TACS_PS2_EXP2;
            2'h3: exp_sel[2] = TACS_PS2_EXP3;
        endcase
        unique case (ps_q[TACS_PS3_LSB +: 2]) // see RULE_02
            2'h0: exp_sel[3] = TACS_PS3_EXP0;
            2'h1: exp_sel[3] = TACS_PS3_EXP1;
            2'h2: exp_sel[3] = TACS_PS3_EXP2;
            2'h3: exp_sel[3] = TACS_PS3_EXP3;
        endcase
        // Pulse when the low k bits are all ones: one cycle every 2^k
        for (int k = 0; k < 4; k++)
        begin
            tick[k] = 1'b1; // see RULE_03 see RULE_21
            for (int b = 0; b < 15; b++)
            begin
                if (4'(b) < exp_sel[k] && !div_q[b])
                    tick[k] = 1'b0;
            end
        end
    end

    // Operation clock, edge detector and count clock per channel
    // Channel 1 may take its input from the alternate route instead of its pin
    logic [CHANNELS-1:0] pin_prev_q;
    logic [CHANNELS-1:0] pin_prev_d;
    logic [CHANNELS-1:0] op_d;
    logic [CHANNELS-1:0] samp_d;
    logic [CHANNELS-1:0] cnt_d;
    logic [CHANNELS-1:0] half_d;
    logic [CHANNELS-1:0] lead_d;
    always_comb
    begin
        pin_prev_d = pin_prev_q;
        for (int i = 0; i < CHANNELS; i++)
        begin
            logic       src;
            logic       rise;
            logic       fall;
            logic       valid;
            logic [1:0] cks;
            logic [1:0] pol;
            rise  = 1'b0;
            fall  = 1'b0;
            valid = 1'b0;
            src   = (i == 1 && input_route_sel) ? alt_sync_q : pin_sync_q[i]; // see RULE_14
            cks   = mode_q[i][TACS_OPCLK_LSB +: 2];
            pol   = mode_q[i][TACS_EDGE_LSB +: 2];
            // Clocks 2 and 3 fall back to clock 0 and 1 on channels 0 and 2
            unique case (cks) // see RULE_11 see RULE_12 see RULE_16
                2'h0: op_d[i] = tick[0];
                2'h1: op_d[i] = (i == 1 || i == 3) ? tick[2] : tick[0];
                2'h2: op_d[i] = tick[1];
                2'h3: op_d[i] = (i == 1 || i == 3) ? tick[3] : tick[1];
            endcase
            // Edge detector samples only on operation clock pulses
            if (op_d[i]) // see RULE_13
            begin
                rise = src && !pin_prev_q[i];
                fall = !src && pin_prev_q[i];
                pin_prev_d[i] = src;
            end
            // Codes 2 and 3 both count either edge; they differ only in trigger use
            if (pol == TACS_EDGE_FALL)
                valid = fall;
            else if (pol == TACS_EDGE_RISE)
                valid = rise;
            else
                valid = rise | fall;
            samp_d[i] = op_d[i];
            cnt_d[i]  = mode_q[i][TACS_CSRC_BIT] ? valid : op_d[i]; // see RULE_14 see RULE_15
            half_d[i] = (i == 1 || i == 3) && mode_q[i][TACS_B11_BIT]; // see RULE_08
            lead_d[i] = (i == 2) && mode_q[i][TACS_B11_BIT]; // see RULE_08
        end
    end

    // Registered outputs keep every output straight from a flop
    // The extra stage costs one cycle of latency on every enable
    logic [3:0]          pclk_q;
    logic [CHANNELS-1:0] op_q;
    logic [CHANNELS-1:0] samp_q;
    logic [CHANNELS-1:0] cnt_q;
    logic [CHANNELS-1:0] half_q;
    logic [CHANNELS-1:0] lead_q;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_q      <= '0;
            pin_prev_q <= '0;
            pclk_q     <= '0;
            op_q       <= '0;
            samp_q     <= '0;
            cnt_q      <= '0;
            half_q     <= '0;
            lead_q     <= '0;
        end
        else
        begin
            div_q      <= div_d;
            pin_prev_q <= pin_prev_d;
            pclk_q     <= tick; // see RULE_03
            op_q       <= op_d;
            samp_q     <= samp_d;
            cnt_q      <= cnt_d;
            half_q     <= half_d;
            lead_q     <= lead_d;
        end
    end

    // Output wiring; channel_running is software's concern, kept only as an unused input
    // Nothing gates on channel_running: rewrite discipline is left to software
    assign reg_rdata       = rdata_q;
    assign prescaled_clock = pclk_q;
    assign op_clock_en     = op_q;
    assign sample_en       = samp_q;
    assign count_clock_en  = cnt_q;
    assign half_width      = half_q;
    assign lead_channel    = lead_q;

    wire logic unused_running = ^channel_running;
endmodule
`default_nettype wire

// *** dv/tacs_monitor.sv ***
// Assertion checker for the timer clock and mode select block
`default_nettype none
module tacs_monitor
    import tacs_pkg::*;
#(
    parameter int CHANNELS = TACS_CHANNELS
)
(
    // Clock and reset
    input wire logic                ref_clk,
    input wire logic                rstn,
    // Register port
    input wire logic [19:0]         reg_addr,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [15:0]         reg_wdata,
    input wire logic [15:0]         reg_rdata,
    // Enables and flags
    input wire logic [3:0]          prescaled_clock,
    input wire logic [CHANNELS-1:0] op_clock_en,
    input wire logic [CHANNELS-1:0] sample_en,
    input wire logic [CHANNELS-1:0] half_width,
    input wire logic [CHANNELS-1:0] lead_channel
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Address decode; odd byte addresses never match a mode word
    logic hit_ps;
    logic hit_mode;
    assign hit_ps   = reg_addr == TACS_PRESCALE_ADDR;
    assign hit_mode = reg_addr[19:3] == TACS_MODE0_ADDR[19:3] && !reg_addr[0];
    // Register read and write properties
    property p_unmapped;
        reg_rd && !hit_ps && !hit_mode |=> reg_rdata == 16'h0000;
    endproperty
    property p_ps_zero;
        reg_rd && hit_ps |=> (reg_rdata & 16'hcc00) == 16'h0000;
    endproperty
    property p_mode_zero;
        reg_rd && hit_mode |=> (reg_rdata & 16'h2030) == 16'h0000;
    endproperty
    property p_ch0_bit11;
        reg_rd && reg_addr == TACS_MODE0_ADDR |=> !reg_rdata[11];
    endproperty
    property p_rdata_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    // Flag properties; the registered flag is seen two samples after the write
    property p_split1;
        reg_wr && reg_addr == TACS_MODE0_ADDR + 20'h2 |-> ##2 half_width[1] == $past(reg_wdata[11], 2);
    endproperty
    property p_lead2;
        reg_wr && reg_addr == TACS_MODE0_ADDR + 20'h4 |-> ##2 lead_channel[2] == $past(reg_wdata[11], 2);
    endproperty
    property p_flags_fixed;
        !half_width[0] && !half_width[2] && !lead_channel[0] && !lead_channel[1] && !lead_channel[3];
    endproperty
    // Pulse shape properties; clock 3 never runs faster than every 256 cycles
    property p_clk2_gap;
        prescaled_clock[2] |=> !prescaled_clock[2];
    endproperty
    property p_clk3_gap;
        prescaled_clock[3] |=> !prescaled_clock[3] [*8];
    endproperty
    property p_sample;
        op_clock_en == sample_en;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_ps_zero: assert property (p_ps_zero) else $error("prescaler reserved bits set");
    a_mode_zero: assert property (p_mode_zero) else $error("mode zero bits set");
    a_ch0_bit11: assert property (p_ch0_bit11) else $error("channel 0 bit 11 set");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    a_split1: assert property (p_split1) else $error("half width flag wrong");
    a_lead2: assert property (p_lead2) else $error("lead flag wrong");
    a_flags_fixed: assert property (p_flags_fixed) else $error("absent flag set");
    a_clk2_gap: assert property (p_clk2_gap) else $error("clock 2 pulse too wide");
    a_clk3_gap: assert property (p_clk3_gap) else $error("clock 3 pulse too close");
    a_sample: assert property (p_sample) else $error("sample and op enables differ");
    // Main scenarios reached
    c_clk3: cover property (prescaled_clock[3]);
    c_split: cover property (half_width[1]);
    c_lead: cover property (lead_channel[2]);
endmodule
bind tacs_top tacs_monitor #(.CHANNELS(CHANNELS)) u_mon (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .prescaled_clock(prescaled_clock), .op_clock_en(op_clock_en), .sample_en(sample_en),
    .half_width(half_width), .lead_channel(lead_channel));
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the timer clock and mode select block
`default_nettype none
module testbench
    import tacs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Stimulus, observed outputs and model state
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [19:0] reg_addr = 20'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0;
    logic [15:0] reg_rdata;
    logic [3:0]  pin = 4'h0;
    logic        alt = 1'b0;
    logic        route = 1'b0;
    logic [3:0]  running = 4'h0;
    logic [3:0]  pclk, op_en, cnt_en, hw, lead;
    logic [15:0] m [6] = '{default: 16'h0};
    int          n_errors = 0;
    int          cmp_count = 0;
    int          seed = 32'h91549fe6;
    int          n;
    // Core clock source never changes here, so no stop sequence is due
    always #5 ref_clk = ~ref_clk;
    tacs_top DUT (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timer_input_pin(pin), .input_route_alt(alt),
        .input_route_sel(route), .channel_running(running), .prescaled_clock(pclk), .op_clock_en(op_en),
        .sample_en(), .count_clock_en(cnt_en), .half_width(hw), .lead_channel(lead));
    // Helpers: index 0..3 modes, 4 prescaler, 5 an unmapped word
    function automatic logic [19:0] adr(input int i);
        return i < 4 ? TACS_MODE0_ADDR + 20'(2 * i) : i == 4 ? TACS_PRESCALE_ADDR : 20'hf0198;
    endfunction
    function automatic int pper(input int k);
        case (k)
            0: return 1 << m[4][3:0];
            1: return 1 << m[4][7:4];
            2: return 1 << (m[4][9:8] == 2'h0 ? 1 : 2 * m[4][9:8]);
            default: return 1 << (8 + 2 * m[4][13:12]);
        endcase
    endfunction
    function automatic int opi(input int ch);
        int idx;
        idx = m[ch][14] ? (m[ch][15] ? 3 : 2) : (m[ch][15] ? 1 : 0);
        return (ch % 2 == 0 && idx > 1) ? idx - 2 : idx;
    endfunction
    function automatic logic sig(input int s, input int k);
        return s == 0 ? pclk[k] : s == 1 ? op_en[k] : cnt_en[k];
    endfunction
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Register access; running is held low while a word is written
    task automatic wr(input int i, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= adr(i);
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        running   <= 4'h0;
        @(posedge ref_clk);
        reg_wr  <= 1'b0;
        running <= 4'($random(seed));
        if (i < 5) m[i] = d & (i == 4 ? 16'h33ff : i == 0 ? 16'hd7cf : 16'hdfcf);
    endtask
    task automatic rdc(input int i);
        @(posedge ref_clk);
        reg_addr <= adr(i);
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        tick();
        chk(reg_rdata, m[i]);
    endtask
    // Interval between two pulses; waits bounded by the slowest ratio
    task automatic per(input int s, input int k, input int p);
        n = 0;
        repeat (4) tick();
        do
        begin
            tick();
            n++;
        end
        while (sig(s, k) !== 1'b1 && n < 40000);
        n = 0;
        do
        begin
            tick();
            n++;
        end
        while (sig(s, k) !== 1'b1 && n < 40000);
        chk(16'(n), 16'(p));
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Hang guard, well beyond the slowest ratio sweep
    initial
    begin
        #900000;
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end
    // Main sequence
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) tick();
        for (int i = 0; i < 6; i++) rdc(i);
        $display("test reset_values done");
        repeat (6)
            for (int i = 0; i < 6; i++)
            begin
                wr(i, 16'($random(seed)) & (i == 4 ? 16'h33ff : 16'hffff));
                rdc(i);
            end
        chk({12'h0, hw}, {12'h0, m[3][11], 1'b0, m[1][11], 1'b0});
        chk({12'h0, lead}, {13'h0, m[2][11], 2'b0});
        $display("test register_words done");
        for (int i = 0; i < 4; i++)
        begin
            wr(4, 16'(i * 16'h1100 + i * 16'h33 + 16'h20));
            for (int k = 0; k < 4; k++) per(0, k, pper(k));
        end
        $display("test prescaler_ratios done");
        wr(4, 16'h0113);
        for (int ch = 0; ch < 4; ch++)
            for (int c = 0; c < 4; c++)
            begin
                wr(ch, 16'(c << 14));
                per(1, ch, pper(opi(ch)));
                per(2, ch, pper(opi(ch)));
            end
        $display("test op_clock_select done");
        wr(4, 16'h0000);
        for (int ch = 0; ch < 4; ch++)
            for (int e = 0; e < 8; e++)
            begin
                wr(ch, 16'(16'h1000 | ((e % 4) << 6)));
                route <= (e > 3);
                n = 0;
                for (int t = 0; t < 40; t++)
                begin
                    @(posedge ref_clk);
                    if (t == 10 || t == 20)
                    begin
                        alt     <= alt ^ (e > 3);
                        pin[ch] <= pin[ch] ^ (e < 4);
                    end
                    #1 n += cnt_en[ch];
                end
                chk(16'(n), 16'((e > 3 && ch != 1) ? 0 : (e % 4 < 2 ? 1 : 2)));
            end
        $display("test edge_count done");
        finish_test();
    end
endmodule
`default_nettype wire
